// >>> design/dap_core.sv
// arithmetic datapath with pointer update and wishbone register access
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/100ps
module dap_core
   import dap_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [INSTR_W-1:0] instr_i,
   input wire logic instr_valid_i,
   output logic [15:0] mem_addr_o,
   output logic mem_ysel_o,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [15:0] mem_wdata_o,
   input wire logic [15:0] mem_rdata_i,
   output logic overflow_flag_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   dap_state_t st_reg;
   dap_state_t st_next;
   dap_instr_t ins;
   logic exec;
   logic is_mem;
   logic [39:0] opa;
   logic [39:0] opb;
   logic [39:0] imm_x;
   logic [39:0] acc;
   logic [39:0] prod;
   logic [15:0] mul_a;
   logic [15:0] mul_b;
   logic mul_sa;
   logic mul_sb;
   logic [5:0] sh;
   logic [40:0] sum;
   logic [39:0] res;
   logic gr_we;
   logic ov_hit;
   logic [15:0] ptr_cur;
   logic [15:0] ptr_addr;
   logic [15:0] ptr_next;
   logic bus_req;
   logic bus_wr;

   assign ins = instr_i;
   assign exec = instr_valid_i;
   assign is_mem = (ins.op == OP_LOAD) || (ins.op == OP_STORE);

   function automatic logic [40:0] addsub(input logic [39:0] a, input logic [39:0] b,
                                          input logic sub);
      logic [40:0] s;
      s = sub ? ({a[39], a} - {b[39], b}) : ({a[39], a} + {b[39], b});
      return {s[40] ^ s[39], s[39:0]};
   endfunction : addsub

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   // ----------------------------------------
   // multiplier and pointer unit
   // ----------------------------------------
   dap_mult u_mult (
      .a_i(mul_a),
      .b_i(mul_b),
      .a_signed_i(mul_sa),
      .b_signed_i(mul_sb),
      .prod_o(prod)
   );

   assign ptr_cur = st_reg.dp[ins.ra];

   dap_ptr_unit u_ptr (
      .ptr_i(ptr_cur),
      .step_i(st_reg.dn[ins.ra]),
      .wrap_i(ins.ra[2] ? st_reg.wrap_y : st_reg.wrap_x),
      .mode_i(ins.rb),
      .addr_o(ptr_addr),
      .next_o(ptr_next)
   );

   assign mem_req_o = exec && is_mem;
   assign mem_we_o = exec && (ins.op == OP_STORE);
   assign mem_addr_o = ptr_addr;
   assign mem_ysel_o = ins.ra[2];
   assign mem_wdata_o = st_reg.gr[ins.rd][31:16];

   // ----------------------------------------
   // arithmetic
   // ----------------------------------------
   always_comb begin
      opa = st_reg.gr[ins.ra];
      opb = st_reg.gr[ins.rb];
      imm_x = {24'h000000, ins.imm};
      acc = st_reg.gr[ins.rd];
      mul_a = opa[31:16];
      mul_b = opb[31:16];
      mul_sa = 1'b1;
      mul_sb = 1'b1;
      sh = ins.op[0] ? ins.imm[5:0] : opb[5:0];
      sum = '0;
      res = acc;
      gr_we = 1'b0;
      ov_hit = 1'b0;
      unique case (ins.op)
         OP_MAC_SU: begin
            mul_b = opb[15:0];
            mul_sb = 1'b0;
         end
         OP_MAC_UU: begin
            mul_a = opa[15:0];
            mul_b = opb[15:0];
            mul_sa = 1'b0;
            mul_sb = 1'b0;
         end
         default: ;
      endcase
      unique case (ins.op)
         OP_MAC_ADD, OP_MAC_SU, OP_MAC_UU, OP_MAC_SUB, OP_MAC_SH1: begin
            if (ins.op == OP_MAC_SH1) begin
               acc = 40'($signed(acc) >>> 1);
            end
            sum = addsub(acc, prod, ins.op == OP_MAC_SUB);
            res = sum[39:0];
            ov_hit = sum[40];
            gr_we = 1'b1;
         end
         OP_MAC_SH16: begin
            res = 40'($signed(acc) >>> 16) + prod;
            gr_we = 1'b1;
         end
         OP_ADD, OP_SUB, OP_ADDI, OP_SUBI, OP_INC, OP_DEC, OP_NEG: begin
            unique case (ins.op)
               OP_ADD: sum = addsub(opa, opb, 1'b0);
               OP_SUB: sum = addsub(opa, opb, 1'b1);
               OP_ADDI: sum = addsub(opa, imm_x, 1'b0);
               OP_SUBI: sum = addsub(opa, imm_x, 1'b1);
               OP_INC: sum = addsub(opa, LT_TRUE, 1'b0);
               OP_DEC: sum = addsub(opa, LT_TRUE, 1'b1);
               default: sum = addsub('0, opa, 1'b1);
            endcase
            // immediate of one is not a valid encoding and is not executed
            gr_we = !((ins.op == OP_ADDI || ins.op == OP_SUBI) && ins.imm == PTR_ONE);
            res = sum[39:0];
            ov_hit = gr_we && sum[40];
         end
         OP_SRA, OP_SRAI, OP_SRL, OP_SRLI, OP_SLL, OP_SLLI: begin
            unique case (ins.op)
               OP_SRA, OP_SRAI: res = 40'($signed(opa) >>> sh);
               OP_SRL, OP_SRLI: res = opa >> sh;
               default: res = opa << sh;
            endcase
            gr_we = 1'b1;
         end
         OP_MUL, OP_AND, OP_OR, OP_XOR, OP_CLR, OP_MOV: begin
            unique case (ins.op)
               OP_MUL: res = prod;
               OP_AND: res = opa & opb;
               OP_OR: res = opa | opb;
               OP_XOR: res = opa ^ opb;
               OP_CLR: res = '0;
               default: res = opa;
            endcase
            gr_we = 1'b1;
         end
         OP_LT: begin
            res = ($signed(opa) < $signed(opb)) ? LT_TRUE : '0;
            gr_we = 1'b1;
         end
         OP_CLIP: begin
            if ($signed(opa) > $signed(CLIP_HI)) begin
               res = CLIP_HI;
            end else if ($signed(opa) < $signed(CLIP_LO)) begin
               res = CLIP_LO;
            end else begin
               res = opa;
            end
            gr_we = 1'b1;
         end
         OP_ROUND: begin
            if ($signed(opa) > $signed(RND_HI)) begin
               res = RND_HI;
            end else if ($signed(opa) < $signed(RND_LO)) begin
               res = RND_LO;
            end else begin
               res = (opa + RND_ADD) & RND_MASK;
            end
            gr_we = 1'b1;
         end
         OP_DIV: begin
            sum = addsub(acc, opa, acc[39] == opa[39]);
            // lsb set when the shifted result is non-negative
            res = {sum[38:0], !sum[38]};
            ov_hit = sum[40];
            gr_we = 1'b1;
         end
         OP_LOAD: begin
            res = {acc[39:32], mem_rdata_i, acc[15:0]};
            gr_we = 1'b1;
         end
         default: ;
      endcase
   end

   // ----------------------------------------
   // state update
   // ----------------------------------------
   assign bus_req = wb_cyc_i && wb_stb_i && !st_reg.ack;
   assign bus_wr = bus_req && wb_we_i;

   always_comb begin
      st_next = st_reg;
      st_next.ack = bus_req;
      if (bus_req) begin
         st_next.rdata = '0;
         if (wb_adr_i == OFS_STAT) begin
            st_next.rdata[STAT_OV_BIT] = st_reg.ov;
         end else if (wb_adr_i == OFS_WRAP_X) begin
            st_next.rdata[15:0] = st_reg.wrap_x;
         end else if (wb_adr_i == OFS_WRAP_Y) begin
            st_next.rdata[15:0] = st_reg.wrap_y;
         end else if (wb_adr_i[7:5] == OFS_DP[7:5]) begin
            st_next.rdata[15:0] = st_reg.dp[wb_adr_i[4:2]];
         end else if (wb_adr_i[7:5] == OFS_DN[7:5]) begin
            st_next.rdata[15:0] = st_reg.dn[wb_adr_i[4:2]];
         end else if (wb_adr_i[7:5] == OFS_GR_LO[7:5]) begin
            st_next.rdata = st_reg.gr[wb_adr_i[4:2]][31:0];
         end else if (wb_adr_i[7:5] == OFS_GR_EXT[7:5]) begin
            st_next.rdata[7:0] = st_reg.gr[wb_adr_i[4:2]][39:32];
         end
      end
      if (bus_wr) begin
         if (wb_adr_i == OFS_STAT && wb_sel_i[0]) begin
            st_next.ov = wb_dat_i[STAT_OV_BIT];
         end else if (wb_adr_i == OFS_WRAP_X) begin
            st_next.wrap_x = 16'(merge({16'h0000, st_reg.wrap_x}, wb_dat_i, wb_sel_i));
         end else if (wb_adr_i == OFS_WRAP_Y) begin
            st_next.wrap_y = 16'(merge({16'h0000, st_reg.wrap_y}, wb_dat_i, wb_sel_i));
         end else if (wb_adr_i[7:5] == OFS_DP[7:5]) begin
            st_next.dp[wb_adr_i[4:2]] =
               16'(merge({16'h0000, st_reg.dp[wb_adr_i[4:2]]}, wb_dat_i, wb_sel_i));
         end else if (wb_adr_i[7:5] == OFS_DN[7:5]) begin
            st_next.dn[wb_adr_i[4:2]] =
               16'(merge({16'h0000, st_reg.dn[wb_adr_i[4:2]]}, wb_dat_i, wb_sel_i));
         end
      end
      // instruction writes override a same-cycle bus write
      if (exec) begin
         if (gr_we) begin
            st_next.gr[ins.rd] = res;
         end
         if (ov_hit) begin
            st_next.ov = 1'b1;
         end
         if (is_mem) begin
            st_next.dp[ins.ra] = ptr_next;
         end
         if (ins.op == OP_SETDP) begin
            st_next.dp[ins.rd] = ins.imm;
         end
         if (ins.op == OP_SETDN) begin
            st_next.dn[ins.rd] = ins.imm;
         end
         if (ins.op == OP_SETDM && !ins.rd[0]) begin
            st_next.wrap_x = ins.imm;
         end
         if (ins.op == OP_SETDM && ins.rd[0]) begin
            st_next.wrap_y = ins.imm;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign wb_ack_o = st_reg.ack;
   assign wb_dat_o = st_reg.rdata;
   assign overflow_flag_o = st_reg.ov;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_acc(logic [2:0] m);
      exec && is_mem && ins.rb == m;
   endsequence

   sequence s_no_dp_write;
      !(exec && (is_mem || ins.op == OP_SETDP)) && !bus_wr;
   endsequence

   AST_PTR_INC: assert property (@(posedge clk_i) disable iff (rst_i)
      s_acc(PM_INC) |=> st_reg.dp[$past(ins.ra)] == $past(ptr_cur) + PTR_ONE)
      else $error("post-increment pointer wrong");
   AST_PTR_DEC: assert property (@(posedge clk_i) disable iff (rst_i)
      s_acc(PM_DEC) |=> st_reg.dp[$past(ins.ra)] == $past(ptr_cur) - PTR_ONE)
      else $error("post-decrement pointer wrong");
   AST_PTR_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
      s_acc(PM_STEP) |=>
         st_reg.dp[$past(ins.ra)] == $past(ptr_cur) + $past(st_reg.dn[ins.ra]))
      else $error("step pointer wrong");
   AST_PTR_BREV: assert property (@(posedge clk_i) disable iff (rst_i)
      s_acc(PM_BREV) |-> mem_addr_o == dap_brev(ptr_cur))
      else $error("bit-reversed address wrong");
   AST_PTR_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      s_no_dp_write |=> st_reg.dp == $past(st_reg.dp))
      else $error("pointer changed without access");
   AST_OV_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      exec && ov_hit |=> st_reg.ov ##1 st_reg.ov || $past(bus_wr))
      else $error("overflow flag not set");
   AST_OV_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
      st_reg.ov && !bus_wr |=> st_reg.ov)
      else $error("overflow flag cleared by operation");
   AST_LT: assert property (@(posedge clk_i) disable iff (rst_i)
      exec && ins.op == OP_LT |=>
         st_reg.gr[$past(ins.rd)] ==
            (($signed($past(opa)) < $signed($past(opb))) ? LT_TRUE : 40'h0000000000))
      else $error("less-than result wrong");
   AST_CLIP: assert property (@(posedge clk_i) disable iff (rst_i)
      exec && ins.op == OP_CLIP |=> $signed(st_reg.gr[$past(ins.rd)]) <= $signed(CLIP_HI)
         && $signed(st_reg.gr[$past(ins.rd)]) >= $signed(CLIP_LO))
      else $error("clip out of range");
   AST_IMM_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
      exec && ins.op == OP_ADDI && ins.imm == PTR_ONE |=> $stable(st_reg.gr))
      else $error("immediate add of one executed");
endmodule : dap_core

// >>> design/dap_pkg.sv
// shared constants, types and helpers for the arithmetic and pointer datapath
package dap_pkg;
   // ----------------------------------------
   // instruction word
   // ----------------------------------------
   localparam int INSTR_W = 32;
   typedef struct packed {
      logic [5:0] op;
      logic [2:0] rd;
      logic [2:0] ra;
      logic [2:0] rb;
      logic rsv;
      logic [15:0] imm;
   } dap_instr_t;

   localparam logic [5:0] OP_NOP = 6'h00;
   localparam logic [5:0] OP_MAC_ADD = 6'h01;
   localparam logic [5:0] OP_MAC_SUB = 6'h02;
   localparam logic [5:0] OP_MAC_SU = 6'h03;
   localparam logic [5:0] OP_MAC_UU = 6'h04;
   localparam logic [5:0] OP_MAC_SH1 = 6'h05;
   localparam logic [5:0] OP_MAC_SH16 = 6'h06;
   localparam logic [5:0] OP_MUL = 6'h07;
   localparam logic [5:0] OP_ADD = 6'h08;
   localparam logic [5:0] OP_ADDI = 6'h09;
   localparam logic [5:0] OP_SUB = 6'h0a;
   localparam logic [5:0] OP_SUBI = 6'h0b;
   localparam logic [5:0] OP_SRA = 6'h0c;
   localparam logic [5:0] OP_SRAI = 6'h0d;
   localparam logic [5:0] OP_SRL = 6'h0e;
   localparam logic [5:0] OP_SRLI = 6'h0f;
   localparam logic [5:0] OP_SLL = 6'h10;
   localparam logic [5:0] OP_SLLI = 6'h11;
   localparam logic [5:0] OP_AND = 6'h12;
   localparam logic [5:0] OP_OR = 6'h13;
   localparam logic [5:0] OP_XOR = 6'h14;
   localparam logic [5:0] OP_LT = 6'h15;
   localparam logic [5:0] OP_CLR = 6'h16;
   localparam logic [5:0] OP_INC = 6'h17;
   localparam logic [5:0] OP_DEC = 6'h18;
   localparam logic [5:0] OP_NEG = 6'h19;
   localparam logic [5:0] OP_CLIP = 6'h1a;
   localparam logic [5:0] OP_ROUND = 6'h1b;
   localparam logic [5:0] OP_DIV = 6'h1c;
   localparam logic [5:0] OP_MOV = 6'h1d;
   localparam logic [5:0] OP_LOAD = 6'h20;
   localparam logic [5:0] OP_STORE = 6'h21;
   localparam logic [5:0] OP_SETDP = 6'h22;
   localparam logic [5:0] OP_SETDN = 6'h23;
   localparam logic [5:0] OP_SETDM = 6'h24;

   // pointer modes, carried in the rb field of load and store
   localparam logic [2:0] PM_PLAIN = 3'h0;
   localparam logic [2:0] PM_INC = 3'h1;
   localparam logic [2:0] PM_DEC = 3'h2;
   localparam logic [2:0] PM_STEP = 3'h3;
   localparam logic [2:0] PM_MOD = 3'h4;
   localparam logic [2:0] PM_BREV = 3'h5;

   // ----------------------------------------
   // arithmetic limits
   // ----------------------------------------
   localparam logic [39:0] CLIP_HI = 40'h007fffffff;
   localparam logic [39:0] CLIP_LO = 40'hff80000000;
   localparam logic [39:0] RND_HI = 40'h007fff0000;
   localparam logic [39:0] RND_LO = 40'hff80000000;
   localparam logic [39:0] RND_ADD = 40'h0000008000;
   localparam logic [39:0] RND_MASK = 40'hffffff0000;
   localparam logic [39:0] LT_TRUE = 40'h0000000001;
   localparam logic [15:0] PTR_ONE = 16'h0001;

   // ----------------------------------------
   // register bus byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_STAT = 8'h00;
   localparam logic [7:0] OFS_WRAP_X = 8'h04;
   localparam logic [7:0] OFS_WRAP_Y = 8'h08;
   localparam logic [7:0] OFS_DP = 8'h20;
   localparam logic [7:0] OFS_DN = 8'h40;
   localparam logic [7:0] OFS_GR_LO = 8'h80;
   localparam logic [7:0] OFS_GR_EXT = 8'ha0;
   localparam int STAT_OV_BIT = 0;

   // ----------------------------------------
   // state of the datapath
   // ----------------------------------------
   typedef struct packed {
      logic [7:0][39:0] gr;
      logic [7:0][15:0] dp;
      logic [7:0][15:0] dn;
      logic [15:0] wrap_x;
      logic [15:0] wrap_y;
      logic ov;
      logic ack;
      logic [31:0] rdata;
   } dap_state_t;
   localparam dap_state_t ST_RESET = '0;

   function automatic logic [15:0] dap_brev(input logic [15:0] v);
      logic [15:0] r;
      r = '0;
      for (int i = 0; i < 16; i++) begin
         r[i] = v[15 - i];
      end
      return r;
   endfunction : dap_brev
endpackage : dap_pkg

// >>> design/dap_mult.sv
// 16 by 16 multiplier with per-operand signedness
`timescale 1ns/100ps
module dap_mult
   import dap_pkg::*;
(
   input wire logic [15:0] a_i,
   input wire logic [15:0] b_i,
   input wire logic a_signed_i,
   input wire logic b_signed_i,
   output logic [39:0] prod_o
);
   logic signed [16:0] ax;
   logic signed [16:0] bx;
   logic signed [33:0] p;

   always_comb begin
      ax = $signed({a_signed_i & a_i[15], a_i});
      bx = $signed({b_signed_i & b_i[15], b_i});
      p = ax * bx;
      prod_o = {{6{p[33]}}, p};
   end
endmodule : dap_mult

// >>> design/dap_ptr_unit.sv
// address presentation and post-access update of one data pointer
`timescale 1ns/100ps
module dap_ptr_unit
   import dap_pkg::*;
(
   input wire logic [15:0] ptr_i,
   input wire logic [15:0] step_i,
   input wire logic [15:0] wrap_i,
   input wire logic [2:0] mode_i,
   output logic [15:0] addr_o,
   output logic [15:0] next_o
);
   logic [15:0] mask;
   logic [16:0] s;
   logic [16:0] wsz;

   always_comb begin
      mask = wrap_i;
      for (int i = 1; i < 16; i++) begin
         mask = mask | (mask >> 1);
      end
      wsz = {1'b0, wrap_i} + 17'h00001;
      s = {1'b0, ptr_i & mask} + {step_i[15], step_i};
      if ($signed(s) > $signed({1'b0, wrap_i})) begin
         s = s - wsz;
      end else if (s[16]) begin
         s = s + wsz;
      end
      addr_o = (mode_i == PM_BREV) ? dap_brev(ptr_i) : ptr_i;
      unique case (mode_i)
         PM_INC: next_o = ptr_i + PTR_ONE;
         PM_DEC: next_o = ptr_i - PTR_ONE;
         PM_STEP: next_o = ptr_i + step_i;
         PM_MOD: next_o = (ptr_i & ~mask) + s[15:0];
         PM_BREV: next_o = ptr_i + step_i;
         default: next_o = ptr_i;
      endcase
   end
endmodule : dap_ptr_unit

// >>> tb/dap_mem_model.sv
// behavioural async-read x and y data memory on the pointer port
`timescale 1ns/100ps
module dap_mem_model (
   input wire logic clk_i,
   input wire logic [15:0] addr_i,
   input wire logic ysel_i,
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] rdata_o
);
   logic [15:0] mem_x [256];
   logic [15:0] mem_y [256];
   logic [15:0] last_reg = 16'h0000;
   always_comb begin
      if (req_i && !we_i) begin
         rdata_o = ysel_i ? mem_y[addr_i[7:0]] : mem_x[addr_i[7:0]];
      end else begin
         rdata_o = ~last_reg;  // idle bus never shows the last word
      end
   end
   always @(posedge clk_i) begin
      if (req_i && !we_i) last_reg <= rdata_o;
      if (req_i && we_i && ysel_i) mem_y[addr_i[7:0]] <= wdata_i;
      if (req_i && we_i && !ysel_i) mem_x[addr_i[7:0]] <= wdata_i;
   end
   initial for (int i = 0; i < 256; i++) begin
      mem_x[i] = 16'(i);
      mem_y[i] = 16'(i);
   end
endmodule : dap_mem_model

// >>> tb/dsp_arith_and_pointer_update_test.sv
// self-checking testbench of the arithmetic and pointer datapath
`timescale 1ns/100ps
module dsp_arith_and_pointer_update_test import dap_pkg::*;;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [31:0] instr_i = '0;
   logic instr_valid_i = 1'b0;
   logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i, addr_seen;
   logic mem_ysel_o, mem_req_o, mem_we_o, overflow_flag_o, wb_ack_o, ysel_seen;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = '0;
   logic [31:0] wb_dat_i = '0;
   logic [31:0] wb_dat_o, d;
   logic [17:0] bus_seen;
   int err_total = 0;
   int n_compared = 0;
   always #2 clk_i = ~clk_i;
   dap_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i),
      .instr_valid_i(instr_valid_i), .mem_addr_o(mem_addr_o), .mem_ysel_o(mem_ysel_o),
      .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
      .mem_rdata_i(mem_rdata_i), .overflow_flag_o(overflow_flag_o), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   dap_mem_model u_mem (.clk_i(clk_i), .addr_i(mem_addr_o), .ysel_i(mem_ysel_o),
      .req_i(mem_req_o), .we_i(mem_we_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic ex(input logic [5:0] op, input logic [2:0] rd, ra, rb, input logic [15:0] imm);
      @(posedge clk_i);
      instr_i <= {op, rd, ra, rb, 1'b0, imm};
      instr_valid_i <= 1'b1;
      #1 addr_seen = mem_addr_o;
      ysel_seen = mem_ysel_o;
      bus_seen = {mem_req_o, mem_we_o, mem_wdata_o};
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
   endtask : ex
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      d = wb_dat_o;
      if (n >= 20) chk(40'h1, 40'h0);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic gr(input int n, input logic [39:0] exp);
      logic [31:0] lo;
      wb(1'b0, 8'(OFS_GR_LO + 4 * n), '0);
      lo = d;
      wb(1'b0, 8'(OFS_GR_EXT + 4 * n), '0);
      chk({d[7:0], lo}, exp);
   endtask : gr
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_ptr();
      logic [2:0] md[6] = '{PM_INC, PM_DEC, PM_STEP, PM_BREV, PM_MOD, PM_PLAIN};
      logic [15:0] ea[6] = '{16'h0010, 16'h0011, 16'h0010, 16'hc800, 16'h0016, 16'h0011};
      logic [15:0] ep[6] = '{16'h0011, 16'h0010, 16'h0013, 16'h0016, 16'h0011, 16'h0011};
      wb(1'b0, 8'h1c, '0);
      chk(40'(d), 40'h0);
      wb(1'b1, OFS_WRAP_X, 32'h7);
      wb(1'b1, OFS_WRAP_Y, 32'hf);
      ex(OP_SETDP, 0, 0, 0, 16'h0010);
      ex(OP_SETDN, 0, 0, 0, 16'h0003);
      for (int i = 0; i < 6; i++) begin
         ex(OP_LOAD, 7, 0, md[i], '0);
         chk(40'(addr_seen), 40'(ea[i]));
         wb(1'b0, OFS_DP, '0);
         chk(40'(d), 40'(ep[i]));
      end
      ex(OP_SETDP, 4, 0, 0, 16'h001e);
      ex(OP_SETDN, 4, 0, 0, 16'h0003);
      ex(OP_LOAD, 7, 4, PM_MOD, '0);
      chk(40'(ysel_seen), 40'h1);
      wb(1'b0, 8'(OFS_DP + 16), '0);
      chk(40'(d), 40'h11);
   endtask : t_ptr
   task automatic t_arith();
      u_mem.mem_x[8'h40] = 16'hffff;
      u_mem.mem_x[8'h41] = 16'h8000;
      u_mem.mem_x[8'h42] = 16'h4000;
      ex(OP_SETDP, 1, 0, 0, 16'h0040);
      ex(OP_LOAD, 1, 1, PM_INC, '0);
      ex(OP_LOAD, 2, 1, PM_INC, '0);
      ex(OP_LOAD, 5, 1, PM_INC, '0);
      ex(OP_SRLI, 2, 2, 0, 16'd16);
      ex(OP_MAC_SU, 3, 1, 2, '0);
      ex(OP_MAC_UU, 4, 2, 2, '0);
      gr(3, 40'hffffff8000);
      gr(4, 40'h0040000000);
      ex(OP_MAC_SH1, 4, 1, 1, '0);
      gr(4, 40'h0020000001);
      ex(OP_MAC_SH16, 4, 1, 1, '0);
      gr(4, 40'h0000002001);
      ex(OP_CLIP, 6, 1, 0, '0);
      gr(6, CLIP_HI);
      ex(OP_ROUND, 6, 1, 0, '0);
      gr(6, RND_HI);
      ex(OP_DIV, 6, 2, 0, '0);
      gr(6, 40'h00fffd0001);
      ex(OP_LT, 6, 2, 1, '0);
      gr(6, LT_TRUE);
      ex(OP_LT, 6, 1, 2, '0);
      gr(6, 40'h0);
   endtask : t_arith
   task automatic t_flag();
      ex(OP_SLLI, 5, 5, 0, 16'd8);
      gr(5, 40'h4000000000);
      ex(OP_ADDI, 6, 5, 0, 16'h0001);
      gr(6, 40'h0);
      chk(40'(overflow_flag_o), 40'h0);
      ex(OP_ADD, 5, 5, 5, '0);
      chk(40'(overflow_flag_o), 40'h1);
      ex(OP_ADD, 6, 2, 2, '0);
      chk(40'(overflow_flag_o), 40'h1);
      wb(1'b1, OFS_STAT, 32'h0);
      #1 chk(40'(overflow_flag_o), 40'h0);
   endtask : t_flag
   task automatic t_ops();
      ex(OP_MUL, 6, 1, 1, '0);
      gr(6, 40'h1);
      ex(OP_MAC_ADD, 6, 1, 1, '0);
      gr(6, 40'h2);
      ex(OP_MAC_SUB, 6, 1, 1, '0);
      gr(6, 40'h1);
      ex(OP_SUB, 6, 4, 6, '0);
      gr(6, 40'h2000);
      ex(OP_SUBI, 6, 6, 0, 16'h0010);
      ex(OP_ADDI, 6, 6, 0, 16'h0002);
      gr(6, 40'h1ff2);
      ex(OP_INC, 6, 6, 0, '0);
      gr(6, 40'h1ff3);
      ex(OP_DEC, 7, 6, 0, '0);
      ex(OP_NEG, 7, 7, 0, '0);
      gr(7, 40'hffffffe00e);
      ex(OP_SRAI, 7, 7, 0, 16'h0004);
      gr(7, 40'hfffffffe00);
      ex(OP_SRL, 7, 7, 4, '0);
      gr(7, 40'h7fffffff00);
      ex(OP_SLL, 7, 7, 4, '0);
      gr(7, 40'hfffffffe00);
      ex(OP_SRA, 7, 7, 4, '0);
      gr(7, 40'hffffffff00);
      ex(OP_AND, 7, 7, 6, '0);
      ex(OP_OR, 7, 7, 4, '0);
      ex(OP_XOR, 7, 7, 6, '0);
      ex(OP_MOV, 0, 7, 0, '0);
      gr(0, 40'h20f2);
      ex(OP_CLR, 7, 0, 0, '0);
      ex(OP_SETDP, 2, 0, 0, 16'h0050);
      ex(OP_STORE, 1, 2, PM_PLAIN, '0);
      chk(40'(bus_seen), 40'h3ffff);
      chk(40'(addr_seen), 40'h50);
      ex(OP_LOAD, 7, 2, PM_PLAIN, '0);
      gr(7, 40'h00ffff0000);
      ex(OP_SETDM, 1, 0, 0, 16'h0003);
      wb(1'b0, OFS_WRAP_Y, '0);
      chk(40'(d), 40'h3);
      chk(40'(overflow_flag_o), 40'h0);
   endtask : t_ops
   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_ptr();
      t_arith();
      t_flag();
      t_ops();
      tally_and_finish();
   end
   initial begin
      #40000;
      err_total++;
      tally_and_finish();
   end
endmodule : dsp_arith_and_pointer_update_test
